// ==== hw/eai_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the loader
`ifndef EAI_CFG_SVH
`define EAI_CFG_SVH

// Register and image checksum word addresses
`define EAI_REG_CFG        13'h0000
`define EAI_REG_STAT       13'h0001
`define EAI_REG_PEND       13'h0006
`define EAI_REG_OPSTAT     13'h0018
`define EAI_REG_FAIL       13'h0024
`define EAI_ADDR_SUM_ALL   13'h0051
`define EAI_ADDR_SUM_RT    13'h01c0

// Master configuration fields
`define EAI_CFG_RT_START_EXECUTE     4
`define EAI_CFG_RT_ENABLE      6
`define EAI_CFG_MONITOR_ENABLE      8

// Master status and reset fields
`define EAI_STAT_READBACK_MISMATCH_FLAG     0
`define EAI_STAT_IMAGE_CHECKSUM_ERROR     1
`define EAI_STAT_RTRST     10
`define EAI_STAT_AUTO_INIT_PIN    15

// Hardware pending interrupt fields
`define EAI_PEND_RT_INT_PENDING      2
`define EAI_PEND_APF       3
`define EAI_PEND_READBACK_MISMATCH_FLAG     13

// Operational status fields
`define EAI_OP_ADDR_HI     15
`define EAI_OP_ADDR_LO     11
`define EAI_OP_PAR         10
`define EAI_OP_LOCK        9

// Reset values
`define EAI_WORD_RESET     16'h0000

// Image extent and sequence lengths
`define EAI_LAST_FULL      13'h1fff
`define EAI_LAST_SHORT     13'h07ff
`define EAI_RT_LIST_N      13'h000a
`define EAI_RT_ILL_BASE    13'h0200
`define EAI_RT_ILL_N       13'h0100
`define EAI_RT_DESC_BASE   13'h0400
`define EAI_RT_DESC_N      13'h0200
`define EAI_CLR_N          3'h4

// Serial memory access
`define EAI_SPI_READ       8'h03
`define EAI_SPI_HDR_BITS   6'h18
`define EAI_SPI_ALL_BITS   6'h28

// Timing
`define EAI_CLK_MHZ        10
`define EAI_LATCH_NS       200
`define EAI_LATCH_CYC      ((`EAI_LATCH_NS * `EAI_CLK_MHZ + 999) / 1000)

// Buffer shape: word address plus data
`define EAI_FIFO_W         29
`define EAI_FIFO_D         8

`endif

// ==== hw/eai_pkg.sv ====
// Types shared by the loader modules
package eai_pkg;

   typedef enum logic [2:0] {
      S_STRAP, S_CLEAR, S_LOAD, S_FINISH, S_RUN
   } eai_phase_type;

   typedef enum logic [1:0] {
      P_IDLE, P_SHIFT
   } eai_spi_type;

   typedef enum logic [1:0] {
      W_IDLE, W_WAIT, W_CHECK
   } eai_wr_type;

   typedef enum logic {
      M_FULL, M_RT
   } eai_mode_type;

endpackage : eai_pkg

// ==== hw/eai_word_if.sv ====
// Word stream between the serial reader and the buffer
`timescale 1ns/1ps
`default_nettype none
`include "eai_cfg.svh"

interface eai_word_if;
   logic [`EAI_FIFO_W-1:0] in_data;
   logic                   in_valid;
   logic                   in_ready;
   logic [`EAI_FIFO_W-1:0] out_data;
   logic                   out_valid;
   logic                   out_ready;

   modport fifo (
      input  in_data, in_valid, out_ready,
      output in_ready, out_data, out_valid
   );
   modport user (
      output in_data, in_valid, out_ready,
      input  in_ready, out_data, out_valid
   );
endinterface : eai_word_if

`default_nettype wire

// ==== hw/eai_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "eai_cfg.svh"

module eai_fifo
   import eai_pkg::*;
#(
   parameter int WIDTH = `EAI_FIFO_W,
   parameter int DEPTH = `EAI_FIFO_D
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Stream
   eai_word_if.fifo port
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } eai_fifo_type;

   eai_fifo_type r;
   eai_fifo_type next_r;
   logic         push;
   logic         pop;

   assign port.in_ready  = (r.cnt != (AW+1)'(DEPTH));
   assign port.out_valid = (r.cnt != '0);
   assign port.out_data  = r.mem[r.rp];
   assign push = port.in_valid & port.in_ready;
   assign pop  = port.out_valid & port.out_ready;

   always_comb begin
      next_r = r;
      if (push) begin
         next_r.mem[r.wp] = port.in_data;
         next_r.wp = r.wp + 1'b1;
      end
      if (pop) begin
         next_r.rp = r.rp + 1'b1;
      end
      // Simultaneous push and pop leave the count unchanged
      if (push && !pop) begin
         next_r.cnt = r.cnt + 1'b1;
      end else if (pop && !push) begin
         next_r.cnt = r.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule : eai_fifo

`default_nettype wire

// ==== hw/eai_loader.sv ====
// Serial memory image loader with terminal soft reset and start decision
//
// Functional notes
// - After copying, terminal start and monitor enable stay zero until decided.
// - Terminal auto-starts before ready if image bits set and parity good.
// - Started terminal reads start bit one; else host sets it after ready.
// - Monitor auto-starts before ready if image bit set; else host sets it.
// - Lock pin high: address and parity come from pins sampled 200ns late.
// - Lock pin low: address, parity and lock bits come from the image.
// - Bad address parity refuses terminal start except the soft reset restart; host may fix status first.
// - Load errors block auto-start; host writes after ready still start.
// - Image holds overall and terminal two's-complement checksums.
// - Word N sits at serial bytes 2N (upper) and 2N+1 (lower).
// - Read-back mismatch sets pending bit 13 and status bit 0.
// - Read-back compare runs during full load and soft reset reloads.
// - First mismatch address goes to fail register; comparing then stops.
// - Fail address register has no function once terminals run.
// - Writing status bit 10 starts a terminal soft reset.
// - Soft reset clears start bit, pending bits 2 and 3, terminal pends.
// - Soft reset clears status, status word, self-test word and time tag.
// - Soft reset reloads terminal registers and tables, checked by checksum.
// - After soft reset terminal restarts only if image enable and start set.
// - Ready stays low for the whole load and rises after the checks.
// - Every loaded word adds to the stored checksum; nonzero sum fails.
// - Checksum failure sets status error bit and raises the interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "eai_cfg.svh"

module eai_loader
   import eai_pkg::*;
(
   // Clock and master reset
   input  wire logic        CLK,
   input  wire logic        RSTN,
   // Strap pins
   input  wire logic        AUTO_INIT_PIN,
   input  wire logic        SHORT_IMAGE_PIN,
   input  wire logic        ADDR_LOCK_PIN,
   input  wire logic [4:0]  TERM_ADDR_PIN,
   input  wire logic        TERM_PARITY_PIN,
   // Serial memory link
   output logic             EE_SCK,
   output logic             EE_CS_N,
   output logic             EE_MOSI,
   input  wire logic        EE_MISO,
   // Host register port
   input  wire logic [12:0] REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   input  wire logic        REG_WR,
   output logic [15:0]      REG_RDATA,
   // Device memory port
   output logic [12:0]      MEM_ADDR,
   output logic [15:0]      MEM_WDATA,
   output logic             MEM_WE,
   input  wire logic [15:0] MEM_RDATA,
   // Status
   output logic             READY,
   output logic             IRQ
);

   typedef struct packed {
      logic [9:0]    sync1;
      logic [9:0]    sync2;
      logic [3:0]    latch_cnt;
      eai_phase_type phase;
      eai_mode_type  mode;
      logic [12:0]   seq_idx;
      logic [12:0]   seq_last;
      logic          seq_done;
      logic [2:0]    clr_idx;
      eai_spi_type   spi;
      logic [1:0]    ph;
      logic [5:0]    bit_cnt;
      logic [23:0]   sh_out;
      logic [15:0]   sh_in;
      logic [12:0]   cur_addr;
      logic          push_valid;
      logic [28:0]   push_data;
      logic          sck;
      logic          cs_n;
      logic          mosi;
      eai_wr_type    wst;
      logic [12:0]   mem_addr;
      logic [15:0]   mem_wdata;
      logic          mem_we;
      logic [15:0]   cfg;
      logic [15:0]   stat;
      logic [15:0]   pend;
      logic [15:0]   opstat;
      logic [15:0]   fail;
      logic          img_rt_start_execute;
      logic          img_rt_enable;
      logic          img_monitor_enable;
      logic [15:0]   sum;
      logic          logged;
      logic          op_started;
      logic          ready;
      logic          irq;
      logic [15:0]   rdata;
   } eai_state_type;

   eai_state_type r;
   eai_state_type next_r;

   eai_word_if word ();

   eai_fifo #(
      .WIDTH (`EAI_FIFO_W),
      .DEPTH (`EAI_FIFO_D)
   ) u_fifo (
      .clk  (CLK),
      .rstn (RSTN),
      .port (word.fifo)
   );

   assign word.in_data   = r.push_data;
   assign word.in_valid  = r.push_valid;
   assign word.out_ready = (r.wst == W_IDLE);

   // Odd parity over address and parity bits is required
   function automatic logic eai_apf(input logic [15:0] op);
      eai_apf = ~^op[`EAI_OP_ADDR_HI:`EAI_OP_PAR];
   endfunction : eai_apf

   // Word address fetched at a given step of each load sequence
   function automatic logic [12:0] eai_seq_addr(input eai_mode_type m,
                                                input logic [12:0]  i);
      logic [12:0] j;
      j = '0;
      eai_seq_addr = i;
      if (m == M_RT) begin
         if (i < `EAI_RT_LIST_N) begin
            case (i[3:0])
               4'h0:    eai_seq_addr = 13'h000f;
               4'h1:    eai_seq_addr = 13'h0012;
               4'h2:    eai_seq_addr = 13'h0013;
               4'h3:    eai_seq_addr = 13'h0016;
               4'h4:    eai_seq_addr = 13'h0017;
               4'h5:    eai_seq_addr = 13'h0019;
               4'h6:    eai_seq_addr = 13'h001c;
               4'h7:    eai_seq_addr = 13'h001d;
               4'h8:    eai_seq_addr = 13'h001f;
               default: eai_seq_addr = 13'h004a;
            endcase
         end else if (i < `EAI_RT_LIST_N + `EAI_RT_ILL_N) begin
            j = i - `EAI_RT_LIST_N;
            eai_seq_addr = `EAI_RT_ILL_BASE + j;
         end else if (i < `EAI_RT_LIST_N + `EAI_RT_ILL_N + `EAI_RT_DESC_N)
         begin
            j = i - `EAI_RT_LIST_N - `EAI_RT_ILL_N;
            eai_seq_addr = `EAI_RT_DESC_BASE + j;
         end else begin
            // Terminal checksum word is summed but not written
            eai_seq_addr = `EAI_ADDR_SUM_RT;
         end
      end
   endfunction : eai_seq_addr

   // Terminal words in memory that a soft reset clears outright
   function automatic logic [12:0] eai_clr_addr(input logic [2:0] i);
      case (i)
         3'h0:    eai_clr_addr = 13'h0009;
         3'h1:    eai_clr_addr = 13'h001a;
         3'h2:    eai_clr_addr = 13'h001e;
         default: eai_clr_addr = 13'h0049;
      endcase
   endfunction : eai_clr_addr

   always_comb begin
      logic [15:0] din;
      logic [12:0] wa;
      logic [15:0] nv;
      logic        err;
      logic        drained;
      din = '0;
      wa = '0;
      nv = '0;
      err = 1'b0;
      drained = 1'b0;
      next_r = r;
      next_r.sync1 = {EE_MISO, AUTO_INIT_PIN, SHORT_IMAGE_PIN, ADDR_LOCK_PIN,
                      TERM_PARITY_PIN, TERM_ADDR_PIN};
      next_r.sync2 = r.sync1;
      next_r.mem_we = 1'b0;
      next_r.pend[`EAI_PEND_APF] = eai_apf(r.opstat);
      drained = r.seq_done && (r.spi == P_IDLE) && !r.push_valid &&
                !word.out_valid && (r.wst == W_IDLE);

      // Serial reader: one read command per byte pair, ascending except the terminal checksum read last on soft reset reload
      case (r.spi)
         P_IDLE: begin
            if (r.push_valid && word.in_ready) begin
               next_r.push_valid = 1'b0;
            end
            if (r.phase == S_LOAD && !r.seq_done && !r.push_valid) begin
               wa = eai_seq_addr(r.mode, r.seq_idx);
               next_r.cur_addr = wa;
               next_r.sh_out = {`EAI_SPI_READ, 2'b00, wa, 1'b0};
               next_r.cs_n = 1'b0;
               next_r.ph = '0;
               next_r.bit_cnt = '0;
               next_r.spi = P_SHIFT;
               next_r.seq_idx = r.seq_idx + 1'b1;
               next_r.seq_done = (r.seq_idx == r.seq_last);
            end
         end
         P_SHIFT: begin
            next_r.ph = r.ph + 1'b1;
            if (r.ph == 2'h0) begin
               // Sample two clocks after the rising edge: synchroniser lag
               next_r.sck = 1'b0;
               if (r.bit_cnt > `EAI_SPI_HDR_BITS) begin
                  next_r.sh_in = {r.sh_in[14:0], r.sync2[9]};
               end
               if (r.bit_cnt == `EAI_SPI_ALL_BITS) begin
                  next_r.cs_n = 1'b1;
                  next_r.push_valid = 1'b1;
                  next_r.push_data = {r.cur_addr, next_r.sh_in};
                  next_r.spi = P_IDLE;
               end else begin
                  next_r.mosi = r.sh_out[23];
                  next_r.sh_out = {r.sh_out[22:0], 1'b0};
               end
            end else if (r.ph == 2'h2) begin
               next_r.sck = 1'b1;
               next_r.bit_cnt = r.bit_cnt + 1'b1;
            end
         end
         default: next_r.spi = P_IDLE;
      endcase

      // Writer: store, read back, compare
      case (r.wst)
         W_IDLE: begin
            if (word.out_valid) begin
               wa = word.out_data[28:16];
               din = word.out_data[15:0];
               next_r.sum = r.sum + din;
               next_r.mem_addr = wa;
               next_r.mem_wdata = din;
               if (wa == `EAI_REG_CFG) begin
                  next_r.img_rt_start_execute = din[`EAI_CFG_RT_START_EXECUTE];
                  next_r.img_rt_enable = din[`EAI_CFG_RT_ENABLE];
                  next_r.img_monitor_enable = din[`EAI_CFG_MONITOR_ENABLE];
                  next_r.cfg = din;
                  next_r.cfg[`EAI_CFG_RT_START_EXECUTE] = 1'b0;
                  next_r.cfg[`EAI_CFG_MONITOR_ENABLE] = 1'b0;
               end else if (wa == `EAI_REG_OPSTAT) begin
                  if (r.opstat[`EAI_OP_LOCK]) begin
                     // Pin-latched address and parity survive the image
                     next_r.opstat = {r.opstat[15:10], din[9:0]};
                  end else begin
                     next_r.opstat = din;
                  end
               end else if (wa == `EAI_REG_STAT || wa == `EAI_REG_PEND ||
                            wa == `EAI_REG_FAIL) begin
                  next_r.mem_we = 1'b0;
               end else if (r.mode == M_RT && wa == `EAI_ADDR_SUM_RT) begin
                  next_r.mem_we = 1'b0;
               end else begin
                  next_r.mem_we = 1'b1;
                  next_r.wst = W_WAIT;
               end
            end
         end
         W_WAIT: next_r.wst = W_CHECK;
         W_CHECK: begin
            next_r.wst = W_IDLE;
            if (MEM_RDATA != r.mem_wdata && !r.logged) begin
               next_r.logged = 1'b1;
               next_r.fail = {3'b000, r.mem_addr};
               next_r.stat[`EAI_STAT_READBACK_MISMATCH_FLAG] = 1'b1;
               next_r.pend[`EAI_PEND_READBACK_MISMATCH_FLAG] = 1'b1;
            end
         end
         default: next_r.wst = W_IDLE;
      endcase

      // Sequence control
      case (r.phase)
         S_STRAP: begin
            next_r.latch_cnt = r.latch_cnt + 1'b1;
            if (r.latch_cnt == 4'(`EAI_LATCH_CYC)) begin
               next_r.opstat = {r.sync2[4:0], r.sync2[5], r.sync2[6],
                                9'h000};
               next_r.stat[`EAI_STAT_AUTO_INIT_PIN] = r.sync2[8];
               next_r.seq_idx = '0;
               next_r.seq_done = 1'b0;
               next_r.sum = '0;
               next_r.mode = M_FULL;
               next_r.seq_last = r.sync2[7] ? `EAI_LAST_SHORT : `EAI_LAST_FULL;
               next_r.phase = r.sync2[8] ? S_LOAD : S_RUN;
            end
         end
         S_CLEAR: begin
            if (r.clr_idx == `EAI_CLR_N) begin
               next_r.phase = S_LOAD;
            end else begin
               next_r.mem_addr = eai_clr_addr(r.clr_idx);
               next_r.mem_wdata = `EAI_WORD_RESET;
               next_r.mem_we = 1'b1;
               next_r.clr_idx = r.clr_idx + 1'b1;
            end
         end
         S_LOAD: begin
            if (drained) begin
               next_r.phase = S_FINISH;
            end
         end
         S_FINISH: begin
            err = r.stat[`EAI_STAT_READBACK_MISMATCH_FLAG] || (r.sum != '0);
            next_r.stat[`EAI_STAT_IMAGE_CHECKSUM_ERROR] = (r.sum != '0);
            if (r.img_rt_start_execute && r.img_rt_enable && !err &&
                (r.mode == M_RT || !eai_apf(r.opstat))) begin
               next_r.cfg[`EAI_CFG_RT_START_EXECUTE] = 1'b1;
               next_r.op_started = 1'b1;
            end
            if (r.mode == M_FULL && r.img_monitor_enable && !err) begin
               next_r.cfg[`EAI_CFG_MONITOR_ENABLE] = 1'b1;
               next_r.op_started = 1'b1;
            end
            next_r.phase = S_RUN;
         end
         S_RUN: begin
            next_r.ready = 1'b1;
            if (!r.ready) begin
               // Interrupt rises with ready, never ahead of it
               next_r.irq = r.stat[`EAI_STAT_READBACK_MISMATCH_FLAG] ||
                            r.stat[`EAI_STAT_IMAGE_CHECKSUM_ERROR];
            end
            if (r.ready && REG_WR) begin
               case (REG_ADDR)
                  `EAI_REG_CFG: begin
                     nv = REG_WDATA;
                     if (nv[`EAI_CFG_RT_START_EXECUTE] && !r.cfg[`EAI_CFG_RT_START_EXECUTE] &&
                         (!nv[`EAI_CFG_RT_ENABLE] || eai_apf(r.opstat))) begin
                        nv[`EAI_CFG_RT_START_EXECUTE] = 1'b0;
                     end
                     next_r.cfg = nv;
                     if (nv[`EAI_CFG_RT_START_EXECUTE] || nv[`EAI_CFG_MONITOR_ENABLE]) begin
                        next_r.op_started = 1'b1;
                     end
                  end
                  `EAI_REG_STAT: begin
                     // Error flags clear by writing one
                     if (REG_WDATA[`EAI_STAT_READBACK_MISMATCH_FLAG]) begin
                        next_r.stat[`EAI_STAT_READBACK_MISMATCH_FLAG] = 1'b0;
                     end
                     if (REG_WDATA[`EAI_STAT_IMAGE_CHECKSUM_ERROR]) begin
                        next_r.stat[`EAI_STAT_IMAGE_CHECKSUM_ERROR] = 1'b0;
                     end
                     if (REG_WDATA[`EAI_STAT_RTRST]) begin
                        next_r.ready = 1'b0;
                        next_r.cfg[`EAI_CFG_RT_START_EXECUTE] = 1'b0;
                        next_r.pend[`EAI_PEND_RT_INT_PENDING] = 1'b0;
                        next_r.pend[`EAI_PEND_APF] = 1'b0;
                        next_r.opstat = `EAI_WORD_RESET;
                        next_r.mode = M_RT;
                        next_r.seq_idx = '0;
                        next_r.seq_done = 1'b0;
                        next_r.seq_last = `EAI_RT_LIST_N + `EAI_RT_ILL_N +
                                          `EAI_RT_DESC_N;
                        next_r.sum = '0;
                        next_r.logged = 1'b0;
                        next_r.clr_idx = '0;
                        next_r.op_started = 1'b0;
                        next_r.phase = S_CLEAR;
                     end
                  end
                  `EAI_REG_PEND: begin
                     if (REG_WDATA[`EAI_PEND_READBACK_MISMATCH_FLAG]) begin
                        next_r.pend[`EAI_PEND_READBACK_MISMATCH_FLAG] = 1'b0;
                     end
                  end
                  `EAI_REG_OPSTAT: next_r.opstat = REG_WDATA;
                  default: next_r.mem_we = r.mem_we & 1'b0;
               endcase
            end
            if (!next_r.stat[`EAI_STAT_READBACK_MISMATCH_FLAG] &&
                !next_r.stat[`EAI_STAT_IMAGE_CHECKSUM_ERROR]) begin
               next_r.irq = 1'b0;
            end
         end
         default: next_r.phase = S_STRAP;
      endcase

      // Host reads show the status word until ready
      if (!r.ready) begin
         next_r.rdata = r.stat;
      end else begin
         case (REG_ADDR)
            `EAI_REG_CFG:    next_r.rdata = r.cfg;
            `EAI_REG_STAT:   next_r.rdata = r.stat;
            `EAI_REG_PEND:   next_r.rdata = r.pend;
            `EAI_REG_OPSTAT: next_r.rdata = r.opstat;
            `EAI_REG_FAIL:   next_r.rdata = r.op_started ? `EAI_WORD_RESET
                                                         : r.fail;
            default:         next_r.rdata = `EAI_WORD_RESET;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         r <= '0;
         r.phase <= S_STRAP;
         r.spi <= P_IDLE;
         r.wst <= W_IDLE;
         r.mode <= M_FULL;
         r.cs_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign EE_SCK    = r.sck;
   assign EE_CS_N   = r.cs_n;
   assign EE_MOSI   = r.mosi;
   assign REG_RDATA = r.rdata;
   assign MEM_ADDR  = r.mem_addr;
   assign MEM_WDATA = r.mem_wdata;
   assign MEM_WE    = r.mem_we;
   assign READY     = r.ready;
   assign IRQ       = r.irq;

endmodule : eai_loader

`default_nettype wire

// ==== tb/eai_loader_props.sv ====
// Concurrent checks on the loader's serial, copy and status pins
`timescale 1ns/1ps
`default_nettype none
module eai_loader_props (
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Watched outputs
   input wire logic EE_SCK,
   input wire logic EE_CS_N,
   input wire logic EE_MOSI,
   input wire logic MEM_WE,
   input wire logic READY,
   input wire logic IRQ
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RSTN);
   sequence s_sel;
      $fell(EE_CS_N);
   endsequence
   sequence s_hold;
      (!EE_CS_N) [*8];
   endsequence
   chk_cs_hold: assert property (s_sel |=> s_hold)
      else $error("select too short");
   chk_cs_gap: assert property ($rose(EE_CS_N) |=> EE_CS_N)
      else $error("no gap between reads");
   chk_load_busy: assert property (!EE_CS_N |-> !READY)
      else $error("ready during fetch");
   chk_copy_busy: assert property (MEM_WE |-> !READY)
      else $error("ready during copy");
   chk_irq_ready: assert property ($rose(IRQ) |-> $rose(READY))
      else $error("irq apart from ready");
   chk_sck_idle: assert property (s_sel |-> !EE_SCK)
      else $error("clock high at select");
   chk_mosi_hold: assert property ($rose(EE_SCK) |-> $stable(EE_MOSI))
      else $error("data moved at rise");
   chk_sck_rate: assert property ($rose(EE_SCK) |=> EE_SCK ##1 !EE_SCK)
      else $error("clock rate off");
endmodule : eai_loader_props
bind eai_loader eai_loader_props eai_loader_props_inst (.CLK(CLK), .RSTN(RSTN),
   .EE_SCK(EE_SCK), .EE_CS_N(EE_CS_N), .EE_MOSI(EE_MOSI), .MEM_WE(MEM_WE),
   .READY(READY), .IRQ(IRQ));
`default_nettype wire

// ==== tb/eai_ee_model.sv ====
// Serial memory model answering one byte pair per read
`timescale 1ns/1ps
`default_nettype none
module eai_ee_model (
   // Serial link
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   output logic     miso
);
   logic [7:0]  m [0:16383];
   logic [23:0] hdr;
   logic [15:0] w;
   logic [15:0] last = 16'hfffe;
   int          n = 0;
   int          bad = 0;
   initial miso = 1'b0;
   always @(negedge cs_n) n = 0;
   // Released line shows no stale bit
   always @(posedge cs_n) miso = ~miso;
   always @(posedge sck) if (!cs_n && n < 40) begin
      if (n < 24) hdr = {hdr[22:0], mosi};
      n = n + 1;
      if (n == 24) begin
         if (hdr !== {8'h03, last + 16'h2}) bad = bad + 1;
         last = hdr[15:0];
         w = {m[hdr[13:0]], m[hdr[13:0] | 14'h1]};
      end
   end
   always @(negedge sck) if (!cs_n && n >= 24 && n < 40) miso = w[39 - n];
endmodule : eai_ee_model
`default_nettype wire

// ==== tb/eai_loader_tb_top.sv ====
// Self-checking bench for the image loader
`timescale 1ns/1ps
`default_nettype none
module eai_loader_tb_top;
   logic        CLK, sck, cs_n, mosi, miso, we, rdy, irq;
   logic        RSTN = 1'b0, wr = 1'b0, auto_pin = 1'b0, lock_pin = 1'b1;
   logic [4:0]  tadr = 5'h03;
   logic [12:0] addr = 13'h0, madr;
   logic [15:0] wdat = 16'h0, rdat, mwd, mrd, sum = 16'h0;
   logic [15:0] ram [0:8191];
   logic [15:0] img [0:2047];
   logic [31:0] rs = 32'h1cf0;
   int          fails = 0, cmp_count = 0, i;
   eai_loader eai_loader_inst (.CLK(CLK), .RSTN(RSTN), .AUTO_INIT_PIN(auto_pin),
      .SHORT_IMAGE_PIN(1'b1), .ADDR_LOCK_PIN(lock_pin), .TERM_ADDR_PIN(tadr),
      .TERM_PARITY_PIN(1'b0), .EE_SCK(sck), .EE_CS_N(cs_n), .EE_MOSI(mosi),
      .EE_MISO(miso), .REG_ADDR(addr), .REG_WDATA(wdat), .REG_WR(wr),
      .REG_RDATA(rdat), .MEM_ADDR(madr), .MEM_WDATA(mwd), .MEM_WE(we),
      .MEM_RDATA(mrd), .READY(rdy), .IRQ(irq));
   eai_ee_model eai_ee_model_inst (.sck(sck), .cs_n(cs_n), .mosi(mosi),
      .miso(miso));
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   // Device RAM; one planted fault proves the read-back path
   always @(posedge CLK) begin
      if (we) ram[madr] <= mwd ^ {15'h0, madr == 13'h0123};
      // Write-through, so the word just written is read back next edge
      mrd <= we ? mwd ^ {15'h0, madr == 13'h0123} : ram[madr];
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   task automatic results();
      if (fails == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrr(input logic [12:0] a, input logic [15:0] d);
      @(negedge CLK);
      addr = a;
      wdat = d;
      wr = 1'b1;
      @(negedge CLK);
      wr = 1'b0;
   endtask : wrr
   task automatic rdc(input logic [12:0] a, input logic [15:0] e);
      @(negedge CLK);
      addr = a;
      @(negedge CLK);
      chk(rdat, e);
   endtask : rdc
   task automatic boot(input logic a, input logic l);
      RSTN = 1'b0;
      auto_pin = a;
      lock_pin = l;
      repeat (16) @(negedge CLK);
      RSTN = 1'b1;
      for (i = 0; i < 400000 && rdy !== 1'b1; i++) @(negedge CLK);
      chk(16'(rdy), 16'h1);
   endtask : boot
   initial begin
      #60000000;
      fails++;
      results();
   end
   initial begin
      for (i = 0; i < 2048; i++) begin
         rs = xs(rs);
         img[i] = rs[15:0];
      end
      img[0] = 16'h0150;
      img[24] = 16'h0800;
      sum = img[15] + img[18] + img[19] + img[22] + img[23] + img[25];
      sum += img[28] + img[29] + img[31] + img[74];
      for (i = 32'h200; i < 32'h600; i++)
         if (i < 32'h300 || i >= 32'h400) sum += img[i];
      img[448] = -sum;
      sum = 16'h0;
      img[81] = 16'h0;
      foreach (img[k]) sum += img[k];
      img[81] = -sum;
      foreach (img[k])
         {eai_ee_model_inst.m[2*k], eai_ee_model_inst.m[2*k+1]} = img[k];
      boot(1'b0, 1'b1);
      rdc(13'h0018, 16'h1a00);
      rdc(13'h0000, 16'h0000);
      wrr(13'h0000, 16'h0050);
      rdc(13'h0000, 16'h0040);
      wrr(13'h0018, 16'h1c00);
      wrr(13'h0000, 16'h0050);
      rdc(13'h0000, 16'h0050);
      rdc(13'h0024, 16'h0000);
      rdc(13'h0003, 16'h0000);
      // Clean image except the planted fault, so only the mismatch path fires
      boot(1'b1, 1'b0);
      chk(16'(irq), 16'h1);
      rdc(13'h0000, 16'h0040);
      rdc(13'h0001, 16'h8001);
      rdc(13'h0006, 16'h2000);
      rdc(13'h0024, 16'h0123);
      rdc(13'h0018, 16'h0800);
      for (i = 'h100; i < 'h800; i += 'h100) chk(ram[i], img[i]);
      chk(16'(eai_ee_model_inst.bad), 16'h0);
      wrr(13'h0000, 16'h0150);
      rdc(13'h0000, 16'h0150);
      rdc(13'h0024, 16'h0000);
      wrr(13'h0001, 16'h0001);
      rdc(13'h0001, 16'h8000);
      chk(16'(irq), 16'h0);
      // Terminal soft reset: clears, reloads tables, restarts from image
      ram[13'h0404] = 16'h0;
      wrr(13'h0001, 16'h0400);
      for (i = 0; i < 200000 && rdy !== 1'b1; i++) @(negedge CLK);
      chk(16'(rdy), 16'h1);
      chk(ram[13'h001e], 16'h0000);
      chk(ram[13'h0404], img[13'h0404]);
      rdc(13'h0018, 16'h0000);
      rdc(13'h0006, 16'h2008);
      rdc(13'h0000, 16'h0150);
      rdc(13'h0001, 16'h8000);
      rdc(13'h0024, 16'h0000);
      chk(16'(irq), 16'h0);
      results();
   end
endmodule : eai_loader_tb_top
`default_nettype wire
